// ---- design/fx_filter_dev.sv ----
// Effects filter block: four mixer-fed low/high-pass filters, compressor knee decode,
// effects rate and underclock admission. Register port via fx_reg_if, audio on plain ports.
// Assumes route samples are synchronous to sys_clk_in and at the effects rate.
`default_nettype none
module fx_filter_dev (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  fx_reg_if.dev bus,
  input wire logic system_clock_running_in,
  input wire fx_pkg::sample_type route_samples_in [fx_pkg::NUM_ROUTE],
  output fx_pkg::sample_type filter_out_out [fx_pkg::NUM_FILT],
  output logic sample_strobe_out,
  output fx_pkg::qdb_type knee_in_qdb_out,
  output fx_pkg::qdb_type knee_out_qdb_out,
  output logic knee_reserved_out,
  output fx_pkg::qdb_type gate_knee_in_qdb_out,
  output fx_pkg::qdb_type gate_knee_out_qdb_out,
  output logic gate_active_out
);
  logic [7:0] src_sel_q [fx_pkg::NUM_SRC];
  logic [7:0] vol_q [fx_pkg::NUM_SRC];
  logic [15:0] coef_q [fx_pkg::NUM_FILT];
  logic [3:0] hpf_q;
  logic [3:0] filt_req_q;
  logic [3:0] active_q;
  logic [3:0] active_d;
  logic [1:0] rate_q;
  logic [1:0] comp_ctl_q;
  logic [10:0] knee_q;
  logic [9:0] gate_q;
  logic [15:0] rdata_q;
  logic ack_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic [15:0] period_cyc;
  logic signed [31:0] lp_q [fx_pkg::NUM_FILT];
  fx_pkg::sample_type out_q [fx_pkg::NUM_FILT];
  logic mix_hit;

  assign mix_hit = (bus.addr >= fx_pkg::MIX_BASE) && (bus.addr <= fx_pkg::MIX_LAST);

  // Sample period per rate code; one rate for all filters
  always_comb
  begin
    case (rate_q)
      2'h0: period_cyc = 16'(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[0]);
      2'h1: period_cyc = 16'(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[1]);
      2'h2: period_cyc = 16'(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[2]);
      default: period_cyc = 16'(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[3]);
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      tick_cnt_q <= 16'h0000;
    else if (tick)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end
  assign tick = (tick_cnt_q >= period_cyc - 16'h0001);
  assign sample_strobe_out = tick;

  // Admission: a new enable only if the period still holds its cost; running paths stay
  always_comb
  begin
    logic [15:0] used;
    used = 16'h0000;
    active_d = active_q;
    for (int f = 0; f < 4; f++)
    begin
      if (active_q[f])
        used = used + 16'(fx_pkg::PATH_COST_CYC);
    end
    if (bus.wr && bus.addr == fx_pkg::FILT_CTRL_ADDR)
    begin
      for (int f = 0; f < 4; f++)
      begin
        if (!bus.wdata[f])
          active_d[f] = 1'b0;
        else if (!active_q[f] && system_clock_running_in
                 && (used + 16'(fx_pkg::PATH_COST_CYC) <= period_cyc))
        begin
          active_d[f] = 1'b1;
          used = used + 16'(fx_pkg::PATH_COST_CYC);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      active_q <= 4'h0;
    else
      active_q <= active_d;
  end

  // Register writes
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < fx_pkg::NUM_SRC; i++)
      begin
        src_sel_q[i] <= fx_pkg::SRC_NONE;
        vol_q[i] <= 8'h80;
      end
      for (int f = 0; f < fx_pkg::NUM_FILT; f++)
        coef_q[f] <= 16'h0000;
      hpf_q <= 4'h0;
      filt_req_q <= 4'h0;
      rate_q <= fx_pkg::RATE_RESET;
      comp_ctl_q <= 2'h0;
      knee_q <= 11'h000;
      gate_q <= 10'h000;
    end
    else if (bus.wr)
    begin
      if (mix_hit && !bus.addr[0])
        src_sel_q[bus.addr[4:1]] <= bus.wdata[7:0];
      if (mix_hit && bus.addr[0])
        vol_q[bus.addr[4:1]] <= bus.wdata[7:0];
      for (int f = 0; f < fx_pkg::NUM_FILT; f++)
      begin
        if (bus.addr == fx_pkg::COEF_ADDR[f])
          coef_q[f] <= bus.wdata;
      end
      if (bus.addr == fx_pkg::FILT_CTRL_ADDR)
      begin
        filt_req_q <= bus.wdata[3:0];
        hpf_q <= bus.wdata[fx_pkg::HPF_LSB +: 4];
      end
      if (bus.addr == fx_pkg::RATE_SEL_ADDR)
        rate_q <= bus.wdata[1:0];
      if (bus.addr == fx_pkg::COMP2_CTRL_ADDR)
        comp_ctl_q <= bus.wdata[1:0];
      if (bus.addr == fx_pkg::COMP2_KNEE_ADDR)
        knee_q <= bus.wdata[10:0];
      if (bus.addr == fx_pkg::COMP2_GATE_ADDR)
        gate_q <= bus.wdata[9:0];
    end
  end

  // Read answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus.wr || bus.rd;
      if (bus.rd)
      begin
        rdata_q <= 16'h0000;
        if (mix_hit)
          rdata_q <= {8'h00, bus.addr[0] ? vol_q[bus.addr[4:1]] : src_sel_q[bus.addr[4:1]]};
        for (int f = 0; f < fx_pkg::NUM_FILT; f++)
        begin
          if (bus.addr == fx_pkg::COEF_ADDR[f])
            rdata_q <= coef_q[f];
        end
        case (bus.addr)
          fx_pkg::FILT_CTRL_ADDR: rdata_q <= {8'h00, hpf_q, filt_req_q};
          fx_pkg::FX_STATUS_ADDR: rdata_q <= {12'h000, active_q};
          fx_pkg::MIX_STATUS_ADDR: rdata_q <= {12'h000, active_q};
          fx_pkg::RATE_SEL_ADDR: rdata_q <= {14'h0000, rate_q};
          fx_pkg::COMP2_CTRL_ADDR: rdata_q <= {14'h0000, comp_ctl_q};
          fx_pkg::COMP2_KNEE_ADDR: rdata_q <= {5'h00, knee_q};
          fx_pkg::COMP2_GATE_ADDR: rdata_q <= {6'h00, gate_q};
          default: ;
        endcase
      end
    end
  end
  assign bus.rdata = rdata_q;
  assign bus.ack = ack_q;

  // Knee decode in quarter dB
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      knee_in_qdb_out <= 10'sd0;
      knee_out_qdb_out <= 10'sd0;
      knee_reserved_out <= 1'b0;
      gate_knee_in_qdb_out <= 10'sd0;
      gate_knee_out_qdb_out <= 10'sd0;
      gate_active_out <= 1'b0;
    end
    else
    begin
      knee_in_qdb_out <= -$signed(10'(knee_q[10:5] * fx_pkg::KNEE_STEP_QDB));
      knee_out_qdb_out <= -$signed(10'(knee_q[4:0] * fx_pkg::KNEE_STEP_QDB));
      knee_reserved_out <= (knee_q[10:5] > fx_pkg::KNEE_IN_LAST) || (knee_q[4:0] > fx_pkg::KNEE_OUT_LAST);
      gate_active_out <= comp_ctl_q[fx_pkg::GATE_EN_BIT];
      // Without the gate the low slope runs on, so gate levels read as zero
      if (!comp_ctl_q[fx_pkg::GATE_EN_BIT])
      begin
        gate_knee_in_qdb_out <= 10'sd0;
        gate_knee_out_qdb_out <= 10'sd0;
      end
      else
      begin
        gate_knee_in_qdb_out <= fx_pkg::GATE_IN_ZERO_QDB - $signed(10'(gate_q[9:5] * fx_pkg::GATE_STEP_QDB));
        if (comp_ctl_q[fx_pkg::KNEE2_OUT_EN_BIT])
          gate_knee_out_qdb_out <= fx_pkg::GATE_OUT_ZERO_QDB
                                   - $signed(10'(gate_q[4:0] * fx_pkg::GATE_STEP_QDB));
        else
          gate_knee_out_qdb_out <= fx_pkg::GATE_IN_ZERO_QDB
                                   - $signed(10'(gate_q[9:5] * fx_pkg::GATE_STEP_QDB));
      end
    end
  end

  // Source lookup: 01h-10h route inputs, 60h-63h filter outputs, others silent
  function automatic fx_pkg::sample_type pick(input logic [7:0] code,
                                              input fx_pkg::sample_type route [fx_pkg::NUM_ROUTE],
                                              input fx_pkg::sample_type fout [fx_pkg::NUM_FILT]);
    fx_pkg::sample_type v;
    v = 16'sh0000;
    if (code >= 8'h01 && code <= 8'h10)
      v = route[4'(code - 8'h01)];
    else if (code >= fx_pkg::SRC_FILT_BASE && code < fx_pkg::SRC_FILT_BASE + 8'h04)
      v = fout[2'(code - fx_pkg::SRC_FILT_BASE)];
    return v;
  endfunction : pick

  // One-pole filter; high-pass is input minus the low-pass state
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      for (int f = 0; f < fx_pkg::NUM_FILT; f++)
      begin
        lp_q[f] <= 32'sh0000_0000;
        out_q[f] <= 16'sh0000;
      end
    end
    else
    begin
      for (int f = 0; f < fx_pkg::NUM_FILT; f++)
      begin
        logic signed [26:0] acc;
        logic signed [19:0] mixed;
        logic signed [15:0] x;
        logic signed [32:0] diff;
        logic signed [49:0] prod;
        logic signed [31:0] lp_n;
        logic signed [16:0] hp;
        acc = 27'sd0;
        for (int i = 0; i < 4; i++)
          acc = acc + 27'(pick(src_sel_q[f * 4 + i], route_samples_in, out_q)
                          * $signed({1'b0, vol_q[f * 4 + i]}));
        mixed = 20'(acc >>> 7);
        x = (mixed > 20'sd32767) ? 16'sh7FFF : (mixed < -20'sd32768) ? 16'sh8000 : mixed[15:0];
        // Keep every operand signed so negative samples extend correctly
        diff = 33'($signed({x, 16'h0000})) - 33'(lp_q[f]);
        prod = 50'(diff * $signed({1'b0, coef_q[f]}));
        lp_n = lp_q[f] + $signed(prod[47:16]);
        hp = 17'(x) - 17'($signed(lp_n[31:16]));
        if (!active_q[f])
        begin
          lp_q[f] <= 32'sh0000_0000;
          out_q[f] <= 16'sh0000;
        end
        else if (tick)
        begin
          lp_q[f] <= lp_n;
          if (!hpf_q[f])
            out_q[f] <= lp_n[31:16];
          else
            out_q[f] <= (hp > 17'sd32767) ? 16'sh7FFF : (hp < -17'sd32768) ? 16'sh8000 : hp[15:0];
        end
      end
    end
  end
  assign filter_out_out = out_q;
endmodule : fx_filter_dev
`default_nettype wire

// ---- design/fx_pkg.sv ----
// Shared constants and types for the effects filter block and its register controller.
// Assumes a single 100 MHz system clock shared by both ends.
`default_nettype none
package fx_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NUM_FILT = 4;
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned NUM_ROUTE = 16;
  // Device register indices (16-bit data each)
  localparam logic [15:0] MIX_BASE = 16'h0900;
  localparam logic [15:0] MIX_LAST = 16'h091F;
  localparam logic [15:0] FX_STATUS_ADDR = 16'h0E01;
  localparam logic [15:0] RATE_SEL_ADDR = 16'h0E00;
  localparam logic [15:0] MIX_STATUS_ADDR = 16'h0640;
  localparam logic [15:0] COMP2_CTRL_ADDR = 16'h0E89;
  localparam logic [15:0] COMP2_KNEE_ADDR = 16'h0E8B;
  localparam logic [15:0] COMP2_GATE_ADDR = 16'h0E8C;
  localparam logic [15:0] FILT_CTRL_ADDR = 16'h0EC0;
  localparam logic [15:0] COEF_ADDR [NUM_FILT] = '{16'h0EC1, 16'h0EC5, 16'h0EC9, 16'h0ECD};
  // Field positions
  localparam int unsigned KNEE_IN_LSB = 5;
  localparam int unsigned GATE_EN_BIT = 1;
  localparam int unsigned KNEE2_OUT_EN_BIT = 0;
  localparam int unsigned HPF_LSB = 4;
  // Knee decode: last valid field codes, then levels and steps in quarter dB
  localparam logic [5:0] KNEE_IN_LAST = 6'h3C;
  localparam logic [4:0] KNEE_OUT_LAST = 5'h1E;
  localparam logic signed [9:0] GATE_IN_ZERO_QDB = -10'sd144;
  localparam logic signed [9:0] GATE_OUT_ZERO_QDB = -10'sd120;
  localparam int unsigned KNEE_STEP_QDB = 3;
  localparam int unsigned GATE_STEP_QDB = 6;
  // Source codes
  localparam logic [7:0] SRC_NONE = 8'h00;
  localparam logic [7:0] SRC_FILT_BASE = 8'h60;
  // Sample rates and processing budget
  localparam int unsigned RATE_HZ [4] = '{48_000, 96_000, 192_000, 16_000};
  localparam int unsigned PATH_COST_CYC = 400;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // Reconfiguration settle time
  localparam int unsigned SETTLE_US = 125;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000));
  // Controller APB map
  localparam logic [7:0] APB_ADDR = 8'h00;
  localparam logic [7:0] APB_WDATA = 8'h04;
  localparam logic [7:0] APB_CMD = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0C;
  localparam int unsigned CMD_WRITE_BIT = 0;
  localparam int unsigned CMD_READ_BIT = 1;
  localparam int unsigned CMD_RATE_BIT = 2;
  typedef logic signed [15:0] sample_type;
  typedef logic signed [9:0] qdb_type;
endpackage : fx_pkg
`default_nettype wire

// ---- design/fx_reg_if.sv ----
// Register port between the controller and the effects block.
// Assumes both ends share sys_clk; one request pulse, one ack pulse.
`default_nettype none
interface fx_reg_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic ack;
  modport ctrl (output addr, output wdata, output wr, output rd, input rdata, input ack);
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output ack);
endinterface : fx_reg_if
`default_nettype wire

// ---- design/fx_reg_ctrl.sv ----
// Register controller: APB slave for software, master of the effects register port.
// Assumes the effects block acks each strobe; refuses rate writes while a selector is live, but only the rate command waits out the settle time.
`default_nettype none
module fx_reg_ctrl #(
  parameter int unsigned SETTLE_CYC = fx_pkg::SETTLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic system_clock_running_in,
  fx_reg_if.ctrl link
);
  typedef enum {IDLE, ACCESS, CLEAR, CLEAR_ACK, SETTLE, RATE} state_type;
  state_type state_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic refused_q;
  logic [15:0] live_q;
  logic [3:0] clr_idx_q;
  logic [15:0] settle_q;
  logic wr_q;
  logic rd_q;
  logic access;
  logic is_sel;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && (paddr > fx_pkg::APB_STATUS);
  assign is_sel = (addr_q >= fx_pkg::MIX_BASE) && (addr_q <= fx_pkg::MIX_LAST) && !addr_q[0];

  always_comb
  begin
    case (paddr)
      fx_pkg::APB_ADDR: prdata = {16'h0000, addr_q};
      fx_pkg::APB_WDATA: prdata = {16'h0000, wdata_q};
      fx_pkg::APB_STATUS: prdata = {rdata_q, 14'h0000, refused_q, state_q != IDLE};
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      state_q <= IDLE;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      refused_q <= 1'b0;
      live_q <= 16'h0000;
      clr_idx_q <= 4'h0;
      settle_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        IDLE:
        begin
          if (access && pwrite && paddr == fx_pkg::APB_ADDR)
            addr_q <= pwdata[15:0];
          if (access && pwrite && paddr == fx_pkg::APB_WDATA)
            wdata_q <= pwdata[15:0];
          if (access && pwrite && paddr == fx_pkg::APB_CMD)
          begin
            refused_q <= 1'b0;
            if (pwdata[fx_pkg::CMD_RATE_BIT])
            begin
              clr_idx_q <= 4'h0;
              state_q <= CLEAR;
            end
            else if (pwdata[fx_pkg::CMD_WRITE_BIT])
            begin
              if ((is_sel && wdata_q[7:0] != fx_pkg::SRC_NONE && !system_clock_running_in)
                  || (addr_q == fx_pkg::RATE_SEL_ADDR && live_q != 16'h0000))
                refused_q <= 1'b1;
              else
              begin
                wr_q <= 1'b1;
                state_q <= ACCESS;
                if (is_sel)
                  live_q[addr_q[4:1]] <= (wdata_q[7:0] != fx_pkg::SRC_NONE);
              end
            end
            else if (pwdata[fx_pkg::CMD_READ_BIT])
            begin
              rd_q <= 1'b1;
              state_q <= ACCESS;
            end
          end
        end
        ACCESS:
        begin
          if (link.ack)
          begin
            rdata_q <= link.rdata;
            state_q <= IDLE;
          end
        end
        CLEAR:
        begin
          wr_q <= 1'b1;
          state_q <= CLEAR_ACK;
        end
        CLEAR_ACK:
        begin
          if (link.ack)
          begin
            live_q[clr_idx_q] <= 1'b0;
            clr_idx_q <= clr_idx_q + 4'h1;
            settle_q <= 16'h0000;
            state_q <= (clr_idx_q == 4'hF) ? SETTLE : CLEAR;
          end
        end
        SETTLE:
        begin
          settle_q <= settle_q + 16'h0001;
          if (settle_q >= 16'(SETTLE_CYC - 1))
          begin
            wr_q <= 1'b1;
            state_q <= RATE;
          end
        end
        RATE:
        begin
          if (link.ack)
            state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // During the clear walk the address follows the selector index
  always_comb
  begin
    link.addr = addr_q;
    link.wdata = wdata_q;
    if (state_q == CLEAR || state_q == CLEAR_ACK)
    begin
      link.addr = fx_pkg::MIX_BASE + {11'h000, clr_idx_q, 1'b0};
      link.wdata = {8'h00, fx_pkg::SRC_NONE};
    end
    else if (state_q == SETTLE || state_q == RATE)
      link.addr = fx_pkg::RATE_SEL_ADDR;
  end
  assign link.wr = wr_q;
  assign link.rd = rd_q;
endmodule : fx_reg_ctrl
`default_nettype wire

// ---- tb/fx_link_checker.sv ----
// Checker for the register link between the controller and the effects block.
// Assumes one clock domain, synchronous active-low reset, and sees the link signals plus system_clock_running_in.
`default_nettype none
module fx_link_checker #(
  parameter int unsigned SETTLE_CYC = fx_pkg::SETTLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic system_clock_running_in,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  logic [15:0] nz_q;
  int unsigned quiet_q;
  logic sel_wr;
  logic rate_wr;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  assign sel_wr = wr && addr >= fx_pkg::MIX_BASE && addr <= fx_pkg::MIX_LAST && !addr[0];
  assign rate_wr = wr && addr == fx_pkg::RATE_SEL_ADDR;
  always_ff @(posedge sys_clk_in)
    if (!rstn_in)
      nz_q <= 16'h0000;
    else if (sel_wr)
      nz_q[addr[4:1]] <= |wdata[7:0];
  // Starts saturated: no selector has been touched since reset
  always_ff @(posedge sys_clk_in)
    if (!rstn_in)
      quiet_q <= SETTLE_CYC;
    else if (sel_wr)
      quiet_q <= 0;
    else if (quiet_q < SETTLE_CYC)
      quiet_q <= quiet_q + 1;
  property p_ack_follows;
    (wr || rd) |=> ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing after strobe");
  property p_ack_cause;
    ack |-> $past(wr || rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  property p_one_out;
    (wr || rd) |-> !(wr && rd) ##1 !(wr || rd);
  endproperty
  a_one_out: assert property (p_one_out) else $error("strobes overlap");
  property p_rate_clear;
    rate_wr |-> nz_q == 16'h0000;
  endproperty
  a_rate_clear: assert property (p_rate_clear) else $error("rate written with live selector");
  property p_rate_settle;
    rate_wr |-> quiet_q >= SETTLE_CYC;
  endproperty
  a_rate_settle: assert property (p_rate_settle) else $error("rate written too soon");
  property p_sel_clock;
    sel_wr && wdata[7:0] != 8'h00 |-> system_clock_running_in;
  endproperty
  a_sel_clock: assert property (p_sel_clock) else $error("selector set without clock");
  property p_status_bits;
    rd && addr == fx_pkg::FX_STATUS_ADDR |=> ack && rdata[15:4] == 12'h000;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status has stray bits");
  property p_unmapped;
    rd && addr == 16'h0A00 |=> ack && rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : fx_link_checker
`default_nettype wire

// ---- tb/effects_filter_and_knee_control_test.sv ----
// Self-checking bench: APB master on the controller, controller and block joined by the link.
// Assumes a 100 MHz clock and a shortened settle count of 20 cycles.
`default_nettype none
module effects_filter_and_knee_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETTLE = 20;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic run_q = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] st_q;
  logic perr_q;
  fx_pkg::sample_type route_q [fx_pkg::NUM_ROUTE] = '{default: 16'h0000};
  fx_pkg::sample_type fout [fx_pkg::NUM_FILT];
  logic strobe;
  logic resv;
  logic gact;
  fx_pkg::qdb_type kin;
  fx_pkg::qdb_type kout;
  fx_pkg::qdb_type gin;
  fx_pkg::qdb_type gout;
  int n_errors = 0;
  int cmp_count = 0;
  fx_reg_if link_if ();
  fx_reg_ctrl #(.SETTLE_CYC(SETTLE)) fx_reg_ctrl_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .system_clock_running_in(run_q), .link(link_if));
  fx_filter_dev fx_filter_dev_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus(link_if),
    .system_clock_running_in(run_q), .route_samples_in(route_q), .filter_out_out(fout), .sample_strobe_out(strobe),
    .knee_in_qdb_out(kin), .knee_out_qdb_out(kout), .knee_reserved_out(resv), .gate_knee_in_qdb_out(gin),
    .gate_knee_out_qdb_out(gout), .gate_active_out(gact));
  fx_link_checker #(.SETTLE_CYC(SETTLE)) fx_link_checker_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .system_clock_running_in(run_q), .addr(link_if.addr), .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd),
    .rdata(link_if.rdata), .ack(link_if.ack));
  initial
  begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic finish_test;
    $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Holds the request until pready is seen high, then idles one cycle so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do
      @(posedge sys_clk_in);
    while (pready !== 1'b1);
    q = prdata;
    perr_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_in);
  endtask : apb
  task automatic dev(input logic [15:0] a, input logic [15:0] d, input logic [2:0] cmd);
    logic [31:0] q;
    apb(1'b1, fx_pkg::APB_ADDR, {16'h0000, a}, q);
    apb(1'b1, fx_pkg::APB_WDATA, {16'h0000, d}, q);
    apb(1'b1, fx_pkg::APB_CMD, {29'h0000_0000, cmd}, q);
    do
      apb(1'b0, fx_pkg::APB_STATUS, 32'h0000_0000, q);
    while (q[0] !== 1'b0);
    st_q = q;
  endtask : dev
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    dev(a, 16'h0000, 3'h2);
    check({16'h0000, st_q[31:16]}, {16'h0000, exp});
  endtask : rd_chk
  function automatic fx_pkg::qdb_type qdb(input int z, input int s, input int c);
    return 10'(z - s * c);
  endfunction : qdb
  function automatic logic near(input fx_pkg::sample_type a, input fx_pkg::sample_type b);
    int d;
    d = int'(a) - int'(b);
    return d >= -2 && d <= 2;
  endfunction : near
  task automatic period(input int exp);
    int n;
    @(posedge sys_clk_in iff strobe === 1'b1);
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end while (strobe !== 1'b1);
    check(n, exp);
  endtask : period
  initial
  begin
    repeat (90000) @(posedge sys_clk_in);
    n_errors++;
    finish_test();
  end
  initial
  begin
    logic [5:0] ki;
    logic [4:0] ko;
    logic [5:0] kin_tab [5] = '{6'h00, 6'h01, 6'h3C, 6'h3D, 6'h3F};
    logic [4:0] kout_tab [5] = '{5'h00, 5'h01, 5'h1E, 5'h1F, 5'h0F};
    fx_pkg::qdb_type ge;
    logic [31:0] aq;
    void'($urandom(32'hF1FF));
    repeat (12) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_chk(fx_pkg::RATE_SEL_ADDR, 16'h0000);
    rd_chk(fx_pkg::MIX_BASE + 16'h0001, 16'h0080);
    rd_chk(fx_pkg::COEF_ADDR[3], 16'h0000);
    rd_chk(16'h0A00, 16'h0000);
    apb(1'b0, fx_pkg::APB_ADDR, 32'h0000_0000, aq);
    check(aq, 32'h0000_0A00);
    check({31'h0, perr_q}, 32'h0);
    apb(1'b0, 8'h10, 32'h0000_0000, aq);
    check({31'h0, perr_q}, 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      ki = (i < 5) ? kin_tab[i] : 6'($urandom());
      ko = (i < 5) ? kout_tab[i] : 5'($urandom());
      dev(fx_pkg::COMP2_KNEE_ADDR, {5'h00, ki, ko}, 3'h1);
      check({31'h0, resv}, {31'h0, ki > 6'h3C || ko == 5'h1F});
      if (ki <= 6'h3C)
        check({22'h0, kin}, {22'h0, qdb(0, 3, ki)});
      if (ko != 5'h1F)
        check({22'h0, kout}, {22'h0, qdb(0, 3, ko)});
    end
    for (int m = 0; m < 4; m++)
    begin
      ki = 6'($urandom()) & 6'h1F;
      ko = 5'($urandom());
      dev(fx_pkg::COMP2_CTRL_ADDR, 16'(m), 3'h1);
      dev(fx_pkg::COMP2_GATE_ADDR, {6'h00, ki[4:0], ko}, 3'h1);
      ge = (m >= 2) ? qdb(-144, 6, ki) : 10'h000;
      check({22'h0, gin}, {22'h0, ge});
      check({22'h0, gout}, {22'h0, (m == 3) ? qdb(-120, 6, ko) : ge});
      check({31'h0, gact}, {31'h0, m >= 2});
    end
    run_q <= 1'b0;
    @(posedge sys_clk_in);
    dev(fx_pkg::MIX_BASE, 16'h0001, 3'h1);
    check({31'h0, st_q[1]}, 32'h1);
    rd_chk(fx_pkg::MIX_BASE, 16'h0000);
    run_q <= 1'b1;
    for (int i = 0; i < 16; i++)
      route_q[i] <= 16'($signed(14'($urandom())));
    for (int f = 0; f < 4; f++)
    begin
      dev(fx_pkg::MIX_BASE + 16'(8 * f), 16'(f + 1), 3'h1);
      dev(fx_pkg::COEF_ADDR[f], 16'hFFFF, 3'h1);
      check({16'h0000, fout[f]}, 32'h0);
    end
    // Filter 1 also takes filter 0's output on its second input
    dev(fx_pkg::MIX_BASE + 16'h000A, {8'h00, fx_pkg::SRC_FILT_BASE}, 3'h1);
    // Filters 2 and 3 run high-pass, so a steady input settles near zero there
    dev(fx_pkg::FILT_CTRL_ADDR, 16'h00CF, 3'h1);
    rd_chk(fx_pkg::FX_STATUS_ADDR, 16'h000F);
    rd_chk(fx_pkg::MIX_STATUS_ADDR, 16'h000F);
    repeat (8) @(posedge sys_clk_in iff strobe === 1'b1);
    for (int f = 0; f < 4; f++)
      check({31'h0, near(fout[f], (f == 1) ? route_q[1] + route_q[0]
                                  : (f == 0) ? route_q[0] : 16'h0000)}, 32'h1);
    period(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[0]);
    dev(fx_pkg::RATE_SEL_ADDR, 16'h0002, 3'h1);
    check({31'h0, st_q[1]}, 32'h1);
    dev(fx_pkg::RATE_SEL_ADDR, 16'h0002, 3'h4);
    rd_chk(fx_pkg::RATE_SEL_ADDR, 16'h0002);
    rd_chk(fx_pkg::MIX_BASE + 16'h0010, 16'h0000);
    rd_chk(fx_pkg::FX_STATUS_ADDR, 16'h000F);
    period(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[2]);
    dev(fx_pkg::FILT_CTRL_ADDR, 16'h0000, 3'h1);
    repeat (2) @(posedge sys_clk_in iff strobe === 1'b1);
    for (int f = 0; f < 4; f++)
      check({16'h0000, fout[f]}, 32'h0);
    // Only one 400-cycle path fits the 192 kHz budget
    dev(fx_pkg::FILT_CTRL_ADDR, 16'h000F, 3'h1);
    dev(fx_pkg::FX_STATUS_ADDR, 16'h0000, 3'h2);
    check($countones(st_q[19:16]), 1);
    rd_chk(fx_pkg::MIX_STATUS_ADDR, st_q[31:16]);
    dev(fx_pkg::RATE_SEL_ADDR, 16'h0003, 3'h4);
    rd_chk(fx_pkg::RATE_SEL_ADDR, 16'h0003);
    period(fx_pkg::CLK_HZ / fx_pkg::RATE_HZ[3]);
    finish_test();
  end
endmodule : effects_filter_and_knee_control_test
`default_nettype wire
